/* File: verilog/cfs_console_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module cfs_console_ctrl (
    input wire logic hclk, // 100 MHz bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hsel, // slave select
    input wire logic [7:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic sec_key_horiz_pin, // security key horizontal
    input wire logic local_locked_pin, // local lock key locked
    input wire logic remote_locked_pin, // remote lock key locked
    input wire logic cpu_stopped_pin, // cpu in manual state
    input wire logic clocks_running_pin, // cpu clocks run
    input wire logic [3:0] sys_ind_pin, // system,manual,wait,test
    input wire logic [63:0] cpu_timer, // timer value, same clock
    input wire logic [63:0] clock_cmp, // comparator, same clock
    input wire logic [63:0] program_status_word, // current word
    input wire logic [31:0] emulator_list, // list address
    output logic [2:0] frame_q, // frame shown on both consoles
    output logic [3:0] manual_ind_q, // indicators on manual frame
    output logic local_kbd_en_q, // local keyboard accepted
    output logic remote_en_q, // remote console operative
    output logic remote_pen_en_q, // remote light pen, always off
    output logic remote_copy_en_q, // remote hard copy, always off
    output logic step_mode_q, // 1 single step, 0 run
    output logic hard_stop_q, // 1 hard stop, 0 process
    output logic ipl_go_q, // accepted load pulse
    output logic alter_go_q, // accepted alteration pulse
    output logic mem_we_q, // store status byte write
    output logic [8:0] mem_addr_q, // store status byte address
    output logic [7:0] mem_data_q // store status byte
);
    import cfs_pkg::*;

    // pins cross in through two flops
    logic [8:0] pin_m_q, pin_s_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // key reads horizontal until the sync fills, no false force
            pin_m_q <= 9'h001;
            pin_s_q <= 9'h001;
        end else begin
            pin_m_q <= {sys_ind_pin, clocks_running_pin, cpu_stopped_pin,
                remote_locked_pin, local_locked_pin, sec_key_horiz_pin};
            pin_s_q <= pin_m_q;
        end
    end
    logic key_h, loc_lk, rem_lk, stopped, clk_run;
    assign key_h = pin_s_q[0];
    assign loc_lk = pin_s_q[1];
    assign rem_lk = pin_s_q[2];
    assign stopped = pin_s_q[3];
    assign clk_run = pin_s_q[4];

    // console access: remote only works with local locked
    logic remote_ok, both_locked, local_ok, free_sel;
    assign remote_ok = loc_lk && !rem_lk;
    assign both_locked = loc_lk && rem_lk;
    assign local_ok = !loc_lk || both_locked;
    assign free_sel = key_h && !both_locked;

    // ahb-lite address phase capture, zero wait states
    logic wr_pend_q, rd_pend_q;
    logic [7:0] addr_q;
    logic acc;
    assign acc = hsel && hready && htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= acc && hwrite;
            rd_pend_q <= acc && !hwrite;
            if (acc) begin
                addr_q <= haddr;
            end
        end
    end
    logic wr_cmd, wr_ctrl, wr_lay;
    assign wr_cmd = wr_pend_q && addr_q == CFS_OFF_CMD;
    assign wr_ctrl = wr_pend_q && addr_q == CFS_OFF_CTRL;
    assign wr_lay = wr_pend_q && addr_q == CFS_OFF_LAYOUT;
    logic [3:0] cmd;
    logic [2:0] cmd_frame;
    logic cmd_remote;
    assign cmd = hwdata[3:0];
    assign cmd_frame = hwdata[6:4];
    assign cmd_remote = hwdata[8]; // command came from remote keyboard

    // source check: a keyboard is heard only when its console is live
    logic src_ok;
    assign src_ok = cmd_remote ? remote_ok : local_ok;

    // frame reachability from the current frame
    function automatic logic cfs_reach(input logic [2:0] from,
            input logic [2:0] to, input logic cfg_done);
        logic r;
        r = 1'b0;
        case (from)
            CFS_FR_MANUAL: r = to == CFS_FR_PROGRAM || to == CFS_FR_SERVICE
                || to == CFS_FR_ALTER || to == CFS_FR_CONFIG;
            CFS_FR_SERVICE: r = to == CFS_FR_PROGRAM || to == CFS_FR_ALTER
                || to == CFS_FR_MANUAL;
            CFS_FR_CONFIG: r = cfg_done && (to == CFS_FR_MANUAL
                || to == CFS_FR_SERVICE);
            default: r = to == CFS_FR_MANUAL;
        endcase
        return r;
    endfunction : cfs_reach

    // frame selection; alter frame needs a stopped, clocked cpu
    logic cfg_done_q, sel_ok, alter_ok;
    assign alter_ok = stopped && clk_run;
    assign sel_ok = cfs_reach(frame_q, cmd_frame, cfg_done_q)
        && (cmd_frame != CFS_FR_ALTER || alter_ok);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            frame_q <= CFS_RST_FRAME;
            cfg_done_q <= 1'b0;
        end else if (!free_sel) begin
            frame_q <= CFS_FR_PROGRAM;
        end else if (frame_q == CFS_FR_ALTER && !alter_ok) begin
            frame_q <= CFS_FR_MANUAL;
        end else if (wr_cmd && src_ok) begin
            case (cmd)
                CFS_CMD_MODEKEY: frame_q <= CFS_FR_MANUAL;
                CFS_CMD_IPL_OK: frame_q <= CFS_FR_PROGRAM;
                CFS_CMD_CFG_DONE: cfg_done_q <= 1'b1;
                CFS_CMD_SELECT: begin
                    if (sel_ok) begin
                        frame_q <= cmd_frame;
                    end
                end
                default: frame_q <= frame_q;
            endcase
        end
    end

    // manual frame controls: run/step and process/hard stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            step_mode_q <= CFS_RST_CTRL[0];
            hard_stop_q <= CFS_RST_CTRL[1];
        end else if (wr_ctrl && frame_q == CFS_FR_MANUAL && free_sel
                && (hwdata[8] ? remote_ok : local_ok)) begin
            step_mode_q <= hwdata[0];
            hard_stop_q <= hwdata[1];
        end
    end

    // load and alteration requests refused when both keys locked
    logic ipl_fire, alt_fire;
    assign ipl_fire = wr_cmd && src_ok && cmd == CFS_CMD_IPL_REQ
        && !both_locked;
    assign alt_fire = wr_cmd && src_ok && cmd == CFS_CMD_ALTER_REQ
        && !both_locked && frame_q == CFS_FR_ALTER && alter_ok;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ipl_go_q <= 1'b0;
            alter_go_q <= 1'b0;
        end else begin
            ipl_go_q <= ipl_fire;
            alter_go_q <= alt_fire;
        end
    end

    // console enables; the remote mirrors the local image
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            local_kbd_en_q <= 1'b0;
            remote_en_q <= 1'b0;
            remote_pen_en_q <= 1'b0;
            remote_copy_en_q <= 1'b0;
            manual_ind_q <= 4'h0;
        end else begin
            local_kbd_en_q <= local_ok;
            remote_en_q <= remote_ok || (both_locked && loc_lk);
            remote_pen_en_q <= 1'b0;
            remote_copy_en_q <= 1'b0;
            manual_ind_q <= frame_q == CFS_FR_MANUAL ? pin_s_q[8:5]
                : 4'h0;
        end
    end

    // store status: walk byte addresses 216..511, skipping gaps
    cfs_ss_state_type ss_q;
    logic [8:0] ss_addr_q;
    logic [63:0] tim_q, cmp_q, psw_q;
    logic [31:0] emu_q;
    logic ss_start;
    assign ss_start = wr_cmd && src_ok && cmd == CFS_CMD_STORE
        && ss_q != CFS_SS_RUN;

    // next byte address of the store sequence
    function automatic logic [8:0] cfs_next(input logic [8:0] a);
        logic [8:0] n;
        n = a + 9'd1;
        if (a == CFS_SS_CMP_HI) begin
            n = CFS_SS_PSW_LO;
        end else if (a == CFS_SS_PSW_HI) begin
            n = CFS_SS_EMU_LO;
        end else if (a == CFS_SS_EMU_HI) begin
            n = CFS_SS_FPR_LO;
        end
        return n;
    endfunction : cfs_next

    // register files, loaded over the data register
    logic [7:0] regbytes_q [0:159];
    logic [7:0] rf_idx_q;
    always_ff @(posedge hclk) begin
        if (wr_pend_q && addr_q == CFS_OFF_SSDATA && rf_idx_q < 8'd160) begin
            regbytes_q[rf_idx_q] <= hwdata[7:0];
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_idx_q <= 8'h00;
        end else if (wr_pend_q && addr_q == CFS_OFF_SSADDR) begin
            rf_idx_q <= hwdata[7:0];
        end else if (wr_pend_q && addr_q == CFS_OFF_SSDATA) begin
            rf_idx_q <= rf_idx_q + 8'd1;
        end
    end

    // byte picked for the current store address, big-endian fields
    logic [7:0] ss_byte;
    logic [8:0] off;
    always_comb begin
        off = 9'd0;
        ss_byte = 8'h00;
        if (ss_addr_q <= CFS_SS_TIMER_HI) begin
            off = ss_addr_q - CFS_SS_TIMER_LO;
            ss_byte = tim_q[8'(63 - 8 * off[2:0]) -: 8];
        end else if (ss_addr_q <= CFS_SS_CMP_HI) begin
            off = ss_addr_q - CFS_SS_CMP_LO;
            ss_byte = cmp_q[8'(63 - 8 * off[2:0]) -: 8];
        end else if (ss_addr_q <= CFS_SS_PSW_HI) begin
            off = ss_addr_q - CFS_SS_PSW_LO;
            ss_byte = psw_q[8'(63 - 8 * off[2:0]) -: 8];
        end else if (ss_addr_q <= CFS_SS_EMU_HI) begin
            off = ss_addr_q - CFS_SS_EMU_LO;
            ss_byte = emu_q[8'(31 - 8 * off[1:0]) -: 8];
        end else begin
            off = ss_addr_q - CFS_SS_FPR_LO;
            ss_byte = regbytes_q[off[7:0]];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ss_q <= CFS_SS_IDLE;
            ss_addr_q <= CFS_SS_TIMER_LO;
            tim_q <= 64'h0;
            cmp_q <= 64'h0;
            psw_q <= 64'h0;
            emu_q <= 32'h0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 9'd0;
            mem_data_q <= 8'h00;
        end else begin
            mem_we_q <= 1'b0;
            case (ss_q)
                CFS_SS_IDLE, CFS_SS_DONE: begin
                    if (ss_start) begin
                        // snapshot so the image is one instant
                        tim_q <= cpu_timer;
                        cmp_q <= clock_cmp;
                        psw_q <= program_status_word;
                        emu_q <= emulator_list;
                        ss_addr_q <= CFS_SS_TIMER_LO;
                        ss_q <= CFS_SS_RUN;
                    end
                end
                CFS_SS_RUN: begin
                    mem_we_q <= 1'b1;
                    mem_addr_q <= ss_addr_q;
                    mem_data_q <= ss_byte;
                    ss_addr_q <= cfs_next(ss_addr_q);
                    if (ss_addr_q == CFS_SS_CR_HI) begin
                        ss_q <= CFS_SS_DONE;
                    end
                end
                default: ss_q <= CFS_SS_IDLE;
            endcase
        end
    end

    // program frame layout: line kind per line number
    logic fs_q;
    logic [4:0] lay_line_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fs_q <= 1'b0;
            lay_line_q <= 5'd1;
        end else if (wr_lay) begin
            fs_q <= hwdata[8]; // full_screen_console_support
            lay_line_q <= hwdata[4:0];
        end
    end
    // kind: 0 unused 1 message 2 key numbers 3 control 4 entry
    //       5 warning 6 status
    logic [2:0] kind;
    always_comb begin
        kind = 3'd0;
        if (lay_line_q == CFS_STATUS_LINE) begin
            kind = 3'd6;
        end else if (lay_line_q == 5'd0) begin
            kind = 3'd0;
        end else if (!fs_q) begin
            kind = lay_line_q <= CFS_PLAIN_MSG_LAST ? 3'd1 : 3'd0;
        end else if (lay_line_q <= CFS_FS_MSG_LAST) begin
            kind = 3'd1;
        end else if (lay_line_q == CFS_FS_KEY_LINE) begin
            kind = 3'd2;
        end else if (lay_line_q == CFS_FS_CTL_LINE) begin
            kind = 3'd3;
        end else if (lay_line_q <= CFS_FS_ENTRY_LAST) begin
            kind = 3'd4;
        end else if (lay_line_q == CFS_FS_WARN_LINE) begin
            kind = 3'd5;
        end
    end

    // read mux; unmapped offsets read zero, response always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (acc && !hwrite) begin
            case (haddr)
                CFS_OFF_CTRL: hrdata <= {30'h0, hard_stop_q, step_mode_q};
                CFS_OFF_STAT: hrdata <= {18'h0, pin_s_q[8:5], ss_q,
                    cfg_done_q, remote_ok, local_ok, frame_q, free_sel};
                CFS_OFF_SSADDR: hrdata <= {24'h0, rf_idx_q};
                CFS_OFF_LAYOUT: hrdata <= {9'h0, CFS_LINE_CHARS, 4'h0,
                    kind, fs_q, 3'h0, lay_line_q};
                default: hrdata <= 32'h0;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : cfs_console_ctrl
`default_nettype wire

/* File: verilog/cfs_pkg.sv */
`default_nettype none
package cfs_pkg;
    // register byte offsets
    localparam logic [7:0] CFS_OFF_CTRL = 8'h00;
    localparam logic [7:0] CFS_OFF_CMD = 8'h04;
    localparam logic [7:0] CFS_OFF_STAT = 8'h08;
    localparam logic [7:0] CFS_OFF_SSADDR = 8'h0C;
    localparam logic [7:0] CFS_OFF_SSDATA = 8'h10;
    localparam logic [7:0] CFS_OFF_LAYOUT = 8'h14;
    // frame codes
    localparam logic [2:0] CFS_FR_PROGRAM = 3'h0;
    localparam logic [2:0] CFS_FR_MANUAL = 3'h1;
    localparam logic [2:0] CFS_FR_SERVICE = 3'h2;
    localparam logic [2:0] CFS_FR_ALTER = 3'h3;
    localparam logic [2:0] CFS_FR_CONFIG = 3'h4;
    // command codes written to the command register
    localparam logic [3:0] CFS_CMD_SELECT = 4'h1;
    localparam logic [3:0] CFS_CMD_MODEKEY = 4'h2;
    localparam logic [3:0] CFS_CMD_IPL_OK = 4'h3;
    localparam logic [3:0] CFS_CMD_STORE = 4'h4;
    localparam logic [3:0] CFS_CMD_IPL_REQ = 4'h5;
    localparam logic [3:0] CFS_CMD_ALTER_REQ = 4'h6;
    localparam logic [3:0] CFS_CMD_CFG_DONE = 4'h7;
    localparam logic [3:0] CFS_CMD_INTKEY = 4'h8;
    // store status area: first byte, last byte
    localparam logic [8:0] CFS_SS_TIMER_LO = 9'd216;
    localparam logic [8:0] CFS_SS_TIMER_HI = 9'd223;
    localparam logic [8:0] CFS_SS_CMP_LO = 9'd224;
    localparam logic [8:0] CFS_SS_CMP_HI = 9'd231;
    localparam logic [8:0] CFS_SS_PSW_LO = 9'd256;
    localparam logic [8:0] CFS_SS_PSW_HI = 9'd263;
    localparam logic [8:0] CFS_SS_EMU_LO = 9'd268;
    localparam logic [8:0] CFS_SS_EMU_HI = 9'd271;
    localparam logic [8:0] CFS_SS_FPR_LO = 9'd352;
    localparam logic [8:0] CFS_SS_FPR_HI = 9'd383;
    localparam logic [8:0] CFS_SS_GPR_LO = 9'd384;
    localparam logic [8:0] CFS_SS_GPR_HI = 9'd447;
    localparam logic [8:0] CFS_SS_CR_LO = 9'd448;
    localparam logic [8:0] CFS_SS_CR_HI = 9'd511;
    // program frame line layout
    localparam logic [4:0] CFS_PLAIN_MSG_LAST = 5'd24;
    localparam logic [4:0] CFS_STATUS_LINE = 5'd25;
    localparam logic [6:0] CFS_LINE_CHARS = 7'd80;
    localparam logic [4:0] CFS_FS_MSG_LAST = 5'd19;
    localparam logic [4:0] CFS_FS_KEY_LINE = 5'd20;
    localparam logic [4:0] CFS_FS_CTL_LINE = 5'd21;
    localparam logic [4:0] CFS_FS_ENTRY_LAST = 5'd23;
    localparam logic [4:0] CFS_FS_WARN_LINE = 5'd24;
    // reset values
    localparam logic [2:0] CFS_RST_FRAME = CFS_FR_CONFIG;
    localparam logic [7:0] CFS_RST_CTRL = 8'h00;
    // store status engine states
    typedef enum logic [2:0] {
        CFS_SS_IDLE = 3'b001,
        CFS_SS_RUN = 3'b010,
        CFS_SS_DONE = 3'b100
    } cfs_ss_state_type;
endpackage : cfs_pkg
`default_nettype wire

/* File: verif/cfs_console_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module cfs_console_chk
    import cfs_pkg::*;
(
    input wire logic hclk, // bus clock
    input wire logic hresetn, // async reset, active low
    input wire logic hreadyout, // slave ready
    input wire logic hresp, // response
    input wire logic sec_key_horiz_pin, // security key
    input wire logic local_locked_pin, // local lock key
    input wire logic remote_locked_pin, // remote lock key
    input wire logic cpu_stopped_pin, // cpu stopped
    input wire logic [2:0] frame_q, // frame shown
    input wire logic [3:0] manual_ind_q, // manual indicators
    input wire logic local_kbd_en_q, // local keyboard live
    input wire logic remote_en_q, // remote console live
    input wire logic remote_pen_en_q, // remote pen
    input wire logic remote_copy_en_q, // remote copy
    input wire logic ipl_go_q, // load pulse
    input wire logic alter_go_q, // alteration pulse
    input wire logic mem_we_q, // store byte strobe
    input wire logic [8:0] mem_addr_q // store byte address
);
    logic [8:0] nxt_addr;
    logic in_area;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // four samples cover the two-flop sync plus the register
    sequence s_key_out; !sec_key_horiz_pin [*4]; endsequence
    sequence s_both_lk; (local_locked_pin && remote_locked_pin) [*4];
    endsequence
    sequence s_rem_only; (local_locked_pin && !remote_locked_pin) [*4];
    endsequence
    // store walk: next byte address, with the jumps between areas
    always_comb begin
        case (mem_addr_q)
            CFS_SS_CMP_HI: nxt_addr = CFS_SS_PSW_LO;
            CFS_SS_PSW_HI: nxt_addr = CFS_SS_EMU_LO;
            CFS_SS_EMU_HI: nxt_addr = CFS_SS_FPR_LO;
            default: nxt_addr = mem_addr_q + 9'd1;
        endcase
    end
    assign in_area = (mem_addr_q inside {[CFS_SS_TIMER_LO:CFS_SS_CMP_HI],
        [CFS_SS_PSW_LO:CFS_SS_PSW_HI], [CFS_SS_EMU_LO:CFS_SS_CR_HI]});
    a_pen_copy_off: assert property (
        !remote_pen_en_q && !remote_copy_en_q) else $error("pen or copy on");
    a_key_out_prog: assert property (
        s_key_out |-> frame_q == CFS_FR_PROGRAM) else $error("frame not prog");
    a_local_unlock: assert property (
        !local_locked_pin [*4] |-> !remote_en_q) else $error("remote live");
    a_remote_only: assert property (
        s_rem_only |-> remote_en_q && !local_kbd_en_q)
        else $error("remote only broken");
    a_both_locked: assert property (
        s_both_lk |-> frame_q == CFS_FR_PROGRAM && !ipl_go_q && !alter_go_q)
        else $error("both locked broken");
    a_alter_stopped: assert property (
        (!cpu_stopped_pin) [*4] |-> frame_q != CFS_FR_ALTER)
        else $error("alter while running");
    a_ind_manual: assert property (
        (frame_q != CFS_FR_MANUAL) [*2] |-> manual_ind_q == 4'h0)
        else $error("indicators outside manual");
    a_store_area: assert property (
        mem_we_q |-> in_area) else $error("store outside area");
    a_store_first: assert property (
        $rose(mem_we_q) |-> mem_addr_q == CFS_SS_TIMER_LO)
        else $error("store start wrong");
    a_store_next: assert property (
        mem_we_q && mem_addr_q != CFS_SS_CR_HI |=>
        mem_we_q && mem_addr_q == $past(nxt_addr)) else $error("store order");
    a_bus_okay: assert property (
        hreadyout && !hresp) else $error("bus not ready");
endmodule : cfs_console_chk
`default_nettype wire

/* File: verif/cfs_console_model.sv */
`timescale 1ns/10ps
`default_nettype none
module cfs_console_model (
    input wire logic hclk, // bus clock
    input wire logic mem_we_q, // store byte strobe
    input wire logic [8:0] mem_addr_q, // store byte address
    input wire logic [7:0] mem_data_q, // store byte
    output logic sec_key_horiz_pin, // security key horizontal
    output logic local_locked_pin, // local key locked
    output logic remote_locked_pin, // remote key locked
    output logic cpu_stopped_pin, // cpu stopped
    output logic clocks_running_pin, // cpu clocks run
    output logic [3:0] sys_ind_pin // system indicators
);
    logic [7:0] mem [0:511];
    int wr_cnt = 0;
    // keys start horizontal, local unlocked, cpu stopped and clocked
    initial begin
        {sec_key_horiz_pin, local_locked_pin, remote_locked_pin} = 3'b101;
        {cpu_stopped_pin, clocks_running_pin, sys_ind_pin} = 6'h30;
    end
    // storage keeps every byte, so stray writes show up later
    always @(posedge hclk) begin
        if (mem_we_q === 1'b1) begin
            mem[mem_addr_q] <= mem_data_q;
            wr_cnt <= wr_cnt + 1;
        end
    end
    // operator turns keys and the cpu changes state just after an edge
    task set_pins(input logic [4:0] p, input logic [3:0] ind);
        @(posedge hclk);
        {sec_key_horiz_pin, local_locked_pin, remote_locked_pin} <= p[4:2];
        {cpu_stopped_pin, clocks_running_pin} <= p[1:0];
        sys_ind_pin <= ind;
    endtask : set_pins
endmodule : cfs_console_model
`default_nettype wire

/* File: verif/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import cfs_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, frame_q;
    logic [31:0] hwdata, hrdata, rd, emulator_list;
    logic [63:0] cpu_timer, clock_cmp, program_status_word;
    logic sec_key_horiz_pin, local_locked_pin, remote_locked_pin;
    logic cpu_stopped_pin, clocks_running_pin, local_kbd_en_q;
    logic remote_en_q, remote_pen_en_q, remote_copy_en_q, step_mode_q;
    logic hard_stop_q, ipl_go_q, alter_go_q, mem_we_q;
    logic [3:0] sys_ind_pin, manual_ind_q;
    logic [8:0] mem_addr_q;
    logic [7:0] mem_data_q;
    logic [7:0] rf [0:159];
    logic [7:0] exp_m [0:511];
    logic [2:0] tgt [0:3];
    integer seed = 32'h458C6E8A;
    int err_total, compares, i, k, n, go_cnt;
    // one slave, so its ready is the bus ready
    assign hready = hreadyout;
    cfs_console_ctrl i_cfs_console_ctrl (.*);
    cfs_console_model m_con (.*);
    always #5 hclk = ~hclk;
    // every accepted load or alteration pulse is counted
    always @(posedge hclk) begin
        if (ipl_go_q === 1'b1 || alter_go_q === 1'b1) begin
            go_cnt <= go_cnt + 1;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task end_of_test;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    // bounded wait for hready; a stuck bus ends the run
    task rdy;
        int w;
        w = 0;
        do begin
            @(posedge hclk);
            w++;
        end while (hreadyout !== 1'b1 && w < 50);
        if (w >= 50) begin
            err_total++;
            end_of_test;
        end
    endtask : rdy
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        {hsel, hwrite, haddr, htrans, hsize} <= {1'b1, w, a, 2'b10, 3'b010};
        rdy;
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, d};
        rdy;
        rd = hrdata;
    endtask : ahb
    task cmd(input logic [3:0] c, input logic [2:0] f, input logic r);
        ahb(1'b1, CFS_OFF_CMD, {23'h0, r, 1'b0, f, c});
    endtask : cmd
    // frame seen through the status register and the port alike
    task frm(input logic [2:0] e);
        ahb(1'b0, CFS_OFF_STAT, 32'h0);
        chk(32'(rd[3:1]), 32'(e));
        chk(32'(frame_q), 32'(e));
    endtask : frm
    // pins pass a two-flop sync, so allow four edges
    task pins(input logic [4:0] p);
        m_con.set_pins(p, k[3:0]);
        repeat (4) @(posedge hclk);
    endtask : pins
    function automatic logic [2:0] kind(input int fs, input int ln);
        if (ln == 25) return 3'd6;
        if (fs == 0 || ln <= 19) return 3'd1;
        if (ln < 22) return 3'(ln - 18);
        return (ln == 24) ? 3'd5 : 3'd4;
    endfunction : kind
    initial begin
        {hclk, hresetn, hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
        {cpu_timer, clock_cmp, program_status_word, emulator_list} = '0;
        tgt = '{CFS_FR_PROGRAM, CFS_FR_SERVICE, CFS_FR_ALTER, CFS_FR_CONFIG};
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        chk(32'(frame_q), 32'(CFS_FR_CONFIG));
        chk(32'({remote_pen_en_q, remote_copy_en_q}), 32'h0);
        chk(32'({step_mode_q, hard_stop_q}), 32'h0);
        chk(32'({local_kbd_en_q, remote_en_q}), 32'h2);
        cmd(CFS_CMD_SELECT, CFS_FR_MANUAL, 1'b0);
        frm(CFS_FR_CONFIG);
        cmd(CFS_CMD_CFG_DONE, 3'h0, 1'b0);
        cmd(CFS_CMD_SELECT, CFS_FR_SERVICE, 1'b0);
        frm(CFS_FR_SERVICE);
        for (i = 0; i < 4; i++) begin
            cmd(CFS_CMD_MODEKEY, 3'h0, 1'b0);
            frm(CFS_FR_MANUAL);
            cmd(CFS_CMD_SELECT, tgt[i], 1'b0);
            frm(tgt[i]);
        end
        cmd(CFS_CMD_MODEKEY, 3'h0, 1'b0);
        k = $random(seed);
        pins(5'b10111);
        frm(CFS_FR_MANUAL);
        chk(32'(manual_ind_q), 32'(k[3:0]));
        chk(32'(rd[13:10]), 32'(k[3:0]));
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, CFS_OFF_CTRL, 32'(i));
            frm(CFS_FR_MANUAL);
            chk(32'({hard_stop_q, step_mode_q}), 32'(i));
        end
        pins(5'b10101);
        cmd(CFS_CMD_SELECT, CFS_FR_ALTER, 1'b0);
        frm(CFS_FR_MANUAL);
        pins(5'b10110);
        cmd(CFS_CMD_SELECT, CFS_FR_ALTER, 1'b0);
        frm(CFS_FR_MANUAL);
        pins(5'b10111);
        for (k = 0; k < 2; k++) begin
            for (i = 1; i <= 25; i++) begin
                ahb(1'b1, CFS_OFF_LAYOUT, 32'(k * 256 + i));
                ahb(1'b0, CFS_OFF_LAYOUT, 32'h0);
                chk(32'(rd[11:9]), 32'(kind(k, i)));
                chk(32'(rd[22:16]), 32'(CFS_LINE_CHARS));
            end
        end
        // register files, then live values, then the store itself
        ahb(1'b1, CFS_OFF_SSADDR, 32'h0);
        for (i = 0; i < 160; i++) begin
            rf[i] = 8'($random(seed));
            ahb(1'b1, CFS_OFF_SSDATA, {24'h0, rf[i]});
            exp_m[352 + i] = rf[i];
        end
        cpu_timer <= {$random(seed), $random(seed)};
        clock_cmp <= {$random(seed), $random(seed)};
        program_status_word <= {$random(seed), $random(seed)};
        emulator_list <= $random(seed);
        cmd(CFS_CMD_STORE, 3'h0, 1'b0);
        for (i = 0; i < 8; i++) begin
            exp_m[216 + i] = cpu_timer[63 - 8 * i -: 8];
            exp_m[224 + i] = clock_cmp[63 - 8 * i -: 8];
            exp_m[256 + i] = program_status_word[63 - 8 * i -: 8];
            if (i < 4) exp_m[268 + i] = emulator_list[31 - 8 * i -: 8];
        end
        n = 0;
        do begin
            ahb(1'b0, CFS_OFF_STAT, 32'h0);
            n++;
        end while (rd[9:7] !== 3'b100 && n < 400);
        if (n >= 400) begin
            err_total++;
            end_of_test;
        end
        for (i = 0; i < 512; i++) chk(32'(m_con.mem[i]), 32'(exp_m[i]));
        chk(m_con.wr_cnt, 188);
        cmd(CFS_CMD_IPL_OK, 3'h0, 1'b0);
        frm(CFS_FR_PROGRAM);
        cmd(CFS_CMD_MODEKEY, 3'h0, 1'b0);
        cmd(CFS_CMD_SELECT, CFS_FR_SERVICE, 1'b0);
        cmd(CFS_CMD_SELECT, CFS_FR_PROGRAM, 1'b0);
        frm(CFS_FR_PROGRAM);
        pins(5'b00111);
        cmd(CFS_CMD_MODEKEY, 3'h0, 1'b0);
        frm(CFS_FR_PROGRAM);
        pins(5'b11011);
        chk(32'({local_kbd_en_q, remote_en_q}), 32'h1);
        cmd(CFS_CMD_MODEKEY, 3'h0, 1'b0);
        frm(CFS_FR_PROGRAM);
        cmd(CFS_CMD_MODEKEY, 3'h0, 1'b1);
        frm(CFS_FR_MANUAL);
        pins(5'b11111);
        frm(CFS_FR_PROGRAM);
        k = go_cnt;
        cmd(CFS_CMD_IPL_REQ, 3'h0, 1'b1);
        cmd(CFS_CMD_IPL_REQ, 3'h0, 1'b0);
        cmd(CFS_CMD_ALTER_REQ, 3'h0, 1'b1);
        cmd(CFS_CMD_SELECT, CFS_FR_MANUAL, 1'b1);
        frm(CFS_FR_PROGRAM);
        chk(go_cnt, k);
        end_of_test;
    end
endmodule : tb_top
bind cfs_console_ctrl cfs_console_chk i_chk (.*);
`default_nettype wire
